// ==== verilog/cvr_pkg.sv ====
// Constants, carrier types and register map of the cell-voltage result block.
// Function
// - 14-bit result sits in bits 15:2
// - Full code range equals 5 V input
// - Disabled, skipped channel keeps its stored data
// - Readback picks arithmetic or filtered result
// - One register per channel, consecutive addresses
package cvr_pkg;

	// ----------------------------------------------------------------
	// Channel geometry
	// ----------------------------------------------------------------
	localparam int CVR_NUM_CH   = 5;
	localparam int CVR_FIRST_CH = 7;
	localparam int CVR_RES_W    = 14;
	localparam int CVR_WORD_W   = 16;
	localparam int CVR_PAD_W    = 2;
	localparam int CVR_DATA_W   = 32;
	localparam int CVR_ADDR_W   = 12;
	localparam int CVR_IDX_W    = 8;
	localparam int CVR_CNT_W    = 16;

	// Full-scale input span of the result code, in millivolts.
	localparam int CVR_FULL_SCALE_MV = 5000;

	// ----------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] CVR_IDX_CH7  = 8'h4D;
	localparam logic [7:0] CVR_IDX_CH8  = 8'h4E;
	localparam logic [7:0] CVR_IDX_CH9  = 8'h4F;
	localparam logic [7:0] CVR_IDX_CH10 = 8'h50;
	localparam logic [7:0] CVR_IDX_CH11 = 8'h51;
	localparam logic [7:0] CVR_IDX_CTRL = 8'h60;
	localparam logic [7:0] CVR_IDX_STAT = 8'h61;

	localparam logic [7:0] CVR_IDX_RES [CVR_NUM_CH] = '{
		CVR_IDX_CH7, CVR_IDX_CH8, CVR_IDX_CH9, CVR_IDX_CH10, CVR_IDX_CH11
	};

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CVR_CTRL_EN_LSB   = 0;
	localparam int CVR_CTRL_SEL_BIT  = 8;
	localparam int CVR_STAT_UPD_LSB  = 0;
	localparam int CVR_STAT_NEW_LSB  = 8;
	localparam int CVR_STAT_CNT_LSB  = 16;
	localparam int CVR_LANE_EN       = 0;
	localparam int CVR_LANE_SEL      = 1;

	localparam logic [13:0] CVR_RES_RST  = 14'h0000;
	localparam logic [4:0]  CVR_EN_RST   = 5'h00;
	localparam logic        CVR_SEL_RST  = 1'b0;
	localparam logic [31:0] CVR_RD_ZERO  = 32'h00000000;
	localparam logic [15:0] CVR_CNT_RST  = 16'h0000;
	localparam logic [15:0] CVR_CNT_ONE  = 16'h0001;
	localparam logic [1:0]  CVR_PAD_ZERO = 2'h0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [CVR_RES_W-1:0] alu;
		logic [CVR_RES_W-1:0] iir;
	} cvr_meas_s;

	typedef struct packed {
		logic [CVR_DATA_W-1:0] prdata;
		logic                  pready;
		logic                  pslverr;
		logic [CVR_NUM_CH-1:0] enable;
		logic                  filt_sel;
		logic [CVR_NUM_CH-1:0] updated;
		logic [CVR_NUM_CH-1:0] fresh;
		logic [CVR_CNT_W-1:0]  scan_cnt;
	} cvr_top_state_s;

endpackage

// ==== verilog/cvr_chan.sv ====
// Storage and readback formatting for one cell-voltage result channel.
`timescale 1ns/1ns

module cvr_chan (
	// Clock and reset
	input  wire logic                               i_clk,
	input  wire logic                               i_sys_rst,
	// Conversion capture
	input  wire logic                               i_capture,
	input  wire cvr_pkg::cvr_meas_s                 i_meas,
	// Readback
	input  wire logic                               i_filt_sel,
	output logic [cvr_pkg::CVR_WORD_W-1:0]          o_word
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cvr_pkg::cvr_meas_s state;
	cvr_pkg::cvr_meas_s next_state;

	// The channel only takes new data when the sequencer reports that it
	// was really converted in the scan that just ended; a skipped channel
	// keeps what it had, so software always sees the last true reading.
	always_comb begin
		next_state = state;
		if (i_capture) begin
			next_state = i_meas;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state.alu <= cvr_pkg::CVR_RES_RST;
			state.iir <= cvr_pkg::CVR_RES_RST;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Readback word
	// ----------------------------------------------------------------
	// The code is passed through unscaled: its full range already spans
	// the full-scale input, so left-justifying it keeps that meaning.
	always_comb begin
		if (i_filt_sel) begin
			o_word = {state.iir, cvr_pkg::CVR_PAD_ZERO};
		end else begin
			o_word = {state.alu, cvr_pkg::CVR_PAD_ZERO};
		end
	end

endmodule

// ==== verilog/cvr_regs.sv ====
// APB register block holding the cell-voltage results of channels 7 to 11.
`timescale 1ns/1ns

module cvr_regs (
	// Clock and reset
	input  wire logic                                         i_clk,
	input  wire logic                                         i_sys_rst,
	// APB slave
	input  wire logic                                         i_psel,
	input  wire logic                                         i_penable,
	input  wire logic                                         i_pwrite,
	input  wire logic [cvr_pkg::CVR_ADDR_W-1:0]               i_paddr,
	input  wire logic [cvr_pkg::CVR_DATA_W-1:0]               i_pwdata,
	input  wire logic [3:0]                                   i_pstrb,
	output logic [cvr_pkg::CVR_DATA_W-1:0]                    o_prdata,
	output logic                                              o_pready,
	output logic                                              o_pslverr,
	// Scan sequencer side
	input  wire logic                                         i_scan_done,
	input  wire logic [cvr_pkg::CVR_NUM_CH-1:0]               i_scan_measured,
	input  wire cvr_pkg::cvr_meas_s [cvr_pkg::CVR_NUM_CH-1:0] i_meas,
	// Controls towards sequencer and filter
	output logic [cvr_pkg::CVR_NUM_CH-1:0]                    o_channel_measure_enable,
	output logic                                              o_filtered_readback_select
);

	// ----------------------------------------------------------------
	// Address decoding
	// ----------------------------------------------------------------
	// Returns the register index held in a byte address.
	function automatic logic [cvr_pkg::CVR_IDX_W-1:0] reg_index(
		input logic [cvr_pkg::CVR_ADDR_W-1:0] addr
	);
		reg_index = addr[cvr_pkg::CVR_IDX_W+1:2];
	endfunction

	// Returns a one-hot mask of the result register that an address hits.
	function automatic logic [cvr_pkg::CVR_NUM_CH-1:0] result_hit(
		input logic [cvr_pkg::CVR_ADDR_W-1:0] addr
	);
		logic [cvr_pkg::CVR_IDX_W-1:0] idx;
		idx = reg_index(addr);
		result_hit = '0;
		for (int ch = 0; ch < cvr_pkg::CVR_NUM_CH; ch++) begin
			if (idx == cvr_pkg::CVR_IDX_RES[ch]) begin
				result_hit[ch] = 1'b1;
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	cvr_pkg::cvr_top_state_s state;
	cvr_pkg::cvr_top_state_s next_state;

	logic [cvr_pkg::CVR_WORD_W-1:0] chan_word [cvr_pkg::CVR_NUM_CH];
	logic [cvr_pkg::CVR_NUM_CH-1:0] capture;

	logic                           setup_phase;
	logic                           access_done;
	logic [cvr_pkg::CVR_NUM_CH-1:0] rd_hit;
	logic [cvr_pkg::CVR_IDX_W-1:0]  rd_idx;

	assign setup_phase = i_psel & ~i_penable;
	assign access_done = i_psel & i_penable & state.pready;
	assign rd_hit      = result_hit(i_paddr);
	assign rd_idx      = reg_index(i_paddr);

	// A channel captures only when the scan has ended and the sequencer
	// reports it converted; disabled channels are skipped upstream.
	assign capture = {cvr_pkg::CVR_NUM_CH{i_scan_done}} & i_scan_measured;

	// ----------------------------------------------------------------
	// Channel storage
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < cvr_pkg::CVR_NUM_CH; ch++) begin : g_chan
		cvr_chan u_chan (
			.i_clk      (i_clk),
			.i_sys_rst  (i_sys_rst),
			.i_capture  (capture[ch]),
			.i_meas     (i_meas[ch]),
			.i_filt_sel (state.filt_sel),
			.o_word     (chan_word[ch])
		);
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Read data are latched at the setup edge so that prdata and pready
	// both leave flip-flops; the price is that a read returns the value
	// present in its setup cycle, one edge before completion.
	always_comb begin
		logic [cvr_pkg::CVR_DATA_W-1:0] rdata;
		logic                           err;
		rdata      = cvr_pkg::CVR_RD_ZERO;
		err        = 1'b0;
		next_state = state;

		// Bus answer: one wait-free access cycle after every setup.
		next_state.pready = setup_phase;

		if (|rd_hit) begin
			for (int ch = 0; ch < cvr_pkg::CVR_NUM_CH; ch++) begin
				if (rd_hit[ch]) begin
					rdata[cvr_pkg::CVR_WORD_W-1:0] = chan_word[ch];
				end
			end
		end else if (rd_idx == cvr_pkg::CVR_IDX_CTRL) begin
			rdata[cvr_pkg::CVR_CTRL_EN_LSB +: cvr_pkg::CVR_NUM_CH] = state.enable;
			rdata[cvr_pkg::CVR_CTRL_SEL_BIT]                      = state.filt_sel;
		end else if (rd_idx == cvr_pkg::CVR_IDX_STAT) begin
			rdata[cvr_pkg::CVR_STAT_UPD_LSB +: cvr_pkg::CVR_NUM_CH] = state.updated;
			rdata[cvr_pkg::CVR_STAT_NEW_LSB +: cvr_pkg::CVR_NUM_CH] = state.fresh;
			rdata[cvr_pkg::CVR_STAT_CNT_LSB +: cvr_pkg::CVR_CNT_W]  = state.scan_cnt;
		end else begin
			err = 1'b1;
		end

		if (setup_phase) begin
			next_state.prdata  = i_pwrite ? cvr_pkg::CVR_RD_ZERO : rdata;
			next_state.pslverr = err;
		end

		// Writes land only at the completing edge. Result and status
		// registers have no write path at all, so a write there is
		// accepted without error and changes nothing.
		if (access_done && i_pwrite && rd_idx == cvr_pkg::CVR_IDX_CTRL) begin
			if (i_pstrb[cvr_pkg::CVR_LANE_EN]) begin
				next_state.enable = i_pwdata[cvr_pkg::CVR_CTRL_EN_LSB +: cvr_pkg::CVR_NUM_CH];
			end
			if (i_pstrb[cvr_pkg::CVR_LANE_SEL]) begin
				next_state.filt_sel = i_pwdata[cvr_pkg::CVR_CTRL_SEL_BIT];
			end
		end

		// Fresh flags: a completed read clears the channel's flag, and a
		// capture in the same cycle sets it again so no result is missed.
		if (access_done && !i_pwrite) begin
			next_state.fresh = state.fresh & ~rd_hit;
		end
		next_state.fresh = next_state.fresh | capture;

		if (i_scan_done) begin
			next_state.updated  = i_scan_measured;
			next_state.scan_cnt = cvr_pkg::CVR_CNT_W'(state.scan_cnt + cvr_pkg::CVR_CNT_ONE);
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state.prdata   <= cvr_pkg::CVR_RD_ZERO;
			state.pready   <= 1'b0;
			state.pslverr  <= 1'b0;
			state.enable   <= cvr_pkg::CVR_EN_RST;
			state.filt_sel <= cvr_pkg::CVR_SEL_RST;
			state.updated  <= cvr_pkg::CVR_EN_RST;
			state.fresh    <= cvr_pkg::CVR_EN_RST;
			state.scan_cnt <= cvr_pkg::CVR_CNT_RST;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_prdata                   = state.prdata;
	assign o_pready                   = state.pready;
	assign o_pslverr                  = state.pslverr;
	assign o_channel_measure_enable   = state.enable;
	assign o_filtered_readback_select = state.filt_sel;

endmodule

// ==== testbench/cvr_regs_checker.sv ====
// Port assertions for the cell-voltage result register block.
`timescale 1ns/1ns

module cvr_regs_checker (
	// Clock and reset
	input wire logic			i_clk,
	input wire logic			i_sys_rst,
	// Register bus
	input wire logic			i_psel,
	input wire logic			i_penable,
	input wire logic			i_pwrite,
	input wire logic [11:0]			i_paddr,
	input wire logic [31:0]			i_pwdata,
	input wire logic [3:0]			i_pstrb,
	input wire logic [31:0]			o_prdata,
	input wire logic			o_pready,
	input wire logic			o_pslverr,
	// Scan side and controls
	input wire logic			i_scan_done,
	input wire logic [4:0]			i_scan_measured,
	input wire cvr_pkg::cvr_meas_s [4:0]	i_meas,
	input wire logic [4:0]			o_channel_measure_enable,
	input wire logic			o_filtered_readback_select
);
	logic [13:0]	alu7;
	logic [13:0]	iir7;
	logic		res_hit;
	logic		rd_done;
	logic		wr_res;

	assign res_hit = i_paddr[9:2] >= cvr_pkg::CVR_IDX_CH7 && i_paddr[9:2] <= cvr_pkg::CVR_IDX_CH11;
	assign rd_done = o_pready && i_penable && !i_pwrite && res_hit;
	assign wr_res = o_pready && i_penable && i_pwrite && res_hit;

	// A shadow of channel 7 ties readback to what the scan really delivered.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			alu7 <= 14'h0000;
			iir7 <= 14'h0000;
		end else if (i_scan_done && i_scan_measured[0]) begin
			alu7 <= i_meas[0].alu;
			iir7 <= i_meas[0].iir;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready one cycle after setup");
	a_ready_once: assert property (o_pready |=> !o_pready)
		else $error("ready held longer than one cycle");
	a_result_ch7: assert property (rd_done && i_paddr[9:2] == cvr_pkg::CVR_IDX_CH7 |->
		o_prdata == {16'h0000, ($past(o_filtered_readback_select) ? $past(iir7) : $past(alu7)), 2'b00})
		else $error("channel 7 readback wrong");
	a_upper_zero: assert property (rd_done |-> o_prdata[31:16] == 16'h0000 && o_prdata[1:0] == 2'b00)
		else $error("unused result bits not zero");
	a_write_quiet: assert property (wr_res |-> !o_pslverr && o_prdata == 32'h00000000)
		else $error("result write answered badly");
	a_ctrl_hold: assert property (wr_res |=> $stable(o_channel_measure_enable) && $stable(o_filtered_readback_select))
		else $error("result write changed controls");
	c_read_iir: cover property (rd_done && o_filtered_readback_select);
	c_scan_skip: cover property (i_scan_done && i_scan_measured != 5'h1F);
	c_bad_addr: cover property (o_pready && o_pslverr);
endmodule

// ==== testbench/cvr_regs_tb.sv ====
// Self-checking bench for the cell-voltage result register block.
`timescale 1ns/1ns

module cvr_regs_tb;
	logic				i_clk = 1'b0;
	logic				i_sys_rst = 1'b1;
	logic				i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0]			i_paddr = 12'h000;
	logic [31:0]			i_pwdata = 32'h00000000;
	logic				i_scan_done = 1'b0;
	logic [4:0]			i_scan_measured = 5'h00;
	cvr_pkg::cvr_meas_s [4:0]	i_meas = '0;
	logic [31:0]			o_prdata;
	logic				o_pready, o_pslverr, o_filtered_readback_select;
	logic [4:0]			o_channel_measure_enable;
	logic [3:0]			i_pstrb = 4'hF;
	logic [38:0]			exp_q[$];
	logic [4:0]			en_m = 5'h00, en_n = 5'h00, upd_m = 5'h00, fresh_m = 5'h00;
	logic [15:0]			cnt_m = 16'h0000;
	logic [13:0]			alu_m[5] = '{default: 14'h0000};
	logic [13:0]			iir_m[5] = '{default: 14'h0000};
	logic				sel_m = 1'b0;
	int				failures = 0, n_tests = 0, seed = 32'h1c75f670;

	cvr_regs u_cvr_regs (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_scan_done,
		.i_scan_measured, .i_meas, .o_channel_measure_enable, .o_filtered_readback_select);

	initial begin
		forever #4 i_clk = ~i_clk;
	end

	task automatic check(input logic [38:0] seen, input logic [38:0] want);
		n_tests++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One APB transfer; the expected answer is noted before the request goes out.
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
		input logic [32:0] want);
		int k;
		exp_q.push_back({sel_m, en_m, want});
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= {2'b00, idx, 2'b00};
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			failures++;
			$display("unexpected at %0t: no ready", $time);
			report_and_stop();
		end else begin
			i_psel <= 1'b0;
			i_penable <= 1'b0;
		end
	endtask

	task automatic rd(input int c);
		xfer(1'b0, cvr_pkg::CVR_IDX_RES[c], 32'h0, {17'h0, sel_m ? iir_m[c] : alu_m[c], 2'b00});
		fresh_m[c] = 1'b0;
	endtask

	task automatic rd_stat;
		xfer(1'b0, cvr_pkg::CVR_IDX_STAT, 32'h0, {1'b0, cnt_m, 3'h0, fresh_m, 3'h0, upd_m});
	endtask

	task automatic scan(input logic [4:0] m);
		cvr_pkg::cvr_meas_s [4:0] v;
		for (int c = 0; c < 5; c++) begin
			v[c] = 28'($random(seed));
			if (m[c]) begin
				alu_m[c] = v[c].alu;
				iir_m[c] = v[c].iir;
			end
		end
		upd_m = m;
		fresh_m = fresh_m | m;
		cnt_m = cnt_m + 16'h0001;
		@(posedge i_clk);
		i_scan_done <= 1'b1;
		i_scan_measured <= m;
		i_meas <= v;
		@(posedge i_clk);
		i_scan_done <= 1'b0;
		i_scan_measured <= ~m;
	endtask

	always @(posedge i_clk) begin
		if (o_pready === 1'b1 && i_penable === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("unexpected at %0t: answer with nothing pending", $time);
			end else begin
				check({o_filtered_readback_select, o_channel_measure_enable, o_pslverr, o_prdata},
					exp_q.pop_front());
			end
		end
	end

	initial begin
		repeat (10) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		for (int c = 0; c < 5; c++) begin
			rd(c);
		end
		xfer(1'b0, 8'h70, 32'h0, {1'b1, 32'h00000000});
		for (int r = 0; r < 6; r++) begin
			scan(5'($random(seed)));
			rd_stat();
			for (int s = 0; s < 2; s++) begin
				en_n = 5'($random(seed));
				xfer(1'b1, cvr_pkg::CVR_IDX_CTRL, {23'h0, s[0], 3'h0, en_n}, 33'h0);
				sel_m = s[0];
				en_m = en_n;
				xfer(1'b0, cvr_pkg::CVR_IDX_CTRL, 32'h0, {24'h0, sel_m, 3'h0, en_m});
				for (int c = 0; c < 5; c++) begin
					rd(c);
				end
			end
		end
		// Lane 1 is off, so the select bit must survive this write.
		i_pstrb <= 4'h1;
		en_n = 5'($random(seed));
		xfer(1'b1, cvr_pkg::CVR_IDX_CTRL, {23'h0, ~sel_m, 3'h0, en_n}, 33'h0);
		en_m = en_n;
		i_pstrb <= 4'hF;
		rd(0);
		for (int c = 0; c < 5; c++) begin
			xfer(1'b1, cvr_pkg::CVR_IDX_RES[c], $random(seed), 33'h0);
			rd(c);
		end
		repeat (4) @(posedge i_clk);
		report_and_stop();
	end
endmodule

bind cvr_regs cvr_regs_checker u_cvr_regs_checker (
	.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
	.o_prdata, .o_pready, .o_pslverr, .i_scan_done, .i_scan_measured, .i_meas,
	.o_channel_measure_enable, .o_filtered_readback_select
);
